/* File: aaie_pkg.sv */
// Overview of operation
// - literal AND: W and k into W, zero flag
// - add W and file: carry, digit carry, zero
// - destination 0 to W, 1 to file
// - AND W with file, zero flag only
// - instruction cycle is four oscillator periods
// - seven-bit file address, 0x00 to 0x7F
package aaie_pkg;
    localparam int aaie_data_w = 8;
    localparam int aaie_addr_w = 7;
    localparam int aaie_insn_w = 14;
    localparam logic [5:0] aaie_op_and_literal_with_working = 6'h39;
    localparam logic [5:0] aaie_op_add_working_and_file = 6'h07;
    localparam logic [5:0] aaie_op_and_working_with_file = 6'h05;
    localparam int aaie_op_hi = 13;
    localparam int aaie_op_lo = 8;
    localparam int aaie_dest_bit = 7;
    localparam logic [7:0] aaie_w_reset = 8'h00;
    localparam logic aaie_dest_working = 1'b0;
    localparam logic aaie_dest_file = 1'b1;
    localparam int aaie_phases = 4;
    localparam int aaie_nibble = 4;
    // phase order is gray coded q1 -> q2 -> q3 -> q4
    typedef enum logic [1:0] {
        aaie_q1 = 2'b00,
        aaie_q2 = 2'b01,
        aaie_q3 = 2'b11,
        aaie_q4 = 2'b10
    } aaie_phase_type;
    typedef enum logic [1:0] {
        aaie_alu_none = 2'b00,
        aaie_alu_and_lit = 2'b01,
        aaie_alu_add_file = 2'b11,
        aaie_alu_and_file = 2'b10
    } aaie_alu_type;
endpackage

/* File: aaie_phase_if.sv */
interface aaie_phase_if;
    import aaie_pkg::*;
    aaie_phase_type phase;
    logic cycle_start;
    modport gen (output phase, output cycle_start);
    modport use_side (input phase, input cycle_start);
endinterface

/* File: aaie_phase_gen.sv */
module aaie_phase_gen
    import aaie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    aaie_phase_if.gen ph
);
    aaie_phase_type phase;
    aaie_phase_type next_phase;

    always_comb begin
        case (phase)
            aaie_q1: next_phase = aaie_q2;
            aaie_q2: next_phase = aaie_q3;
            aaie_q3: next_phase = aaie_q4;
            aaie_q4: next_phase = aaie_q1;
            default: next_phase = aaie_q1;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            phase <= aaie_q1;
        end else begin
            phase <= next_phase;
        end
    end

    assign ph.phase = phase;
    assign ph.cycle_start = (phase == aaie_q1);

    a_phase_order: assert property (
        @(posedge clk_sys) disable iff (rst)
        (phase == aaie_q1) |=> (phase == aaie_q2) ##1 (phase == aaie_q3)
        ##1 (phase == aaie_q4) ##1 (phase == aaie_q1))
        else $error("phase sequence broken");
endmodule

/* File: aaie_exec.sv */
module aaie_exec (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // instruction word, sampled in q1
    input wire logic [aaie_pkg::aaie_insn_w-1:0] insn,
    // file register read data, valid in q2
    input wire logic [aaie_pkg::aaie_data_w-1:0] file_rdata,
    // file register port
    output logic [aaie_pkg::aaie_addr_w-1:0] file_addr,
    output logic file_rd,
    output logic file_we,
    output logic [aaie_pkg::aaie_data_w-1:0] file_wdata,
    // working register and flags
    output logic [aaie_pkg::aaie_data_w-1:0] working,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    // phase and decode status
    output logic [1:0] phase,
    output logic insn_valid
);
    import aaie_pkg::*;

    aaie_phase_if ph();

    aaie_phase_gen u_phase (
        .clk_sys(clk_sys),
        .rst(rst),
        .ph(ph)
    );

    aaie_alu_type op, next_op;
    logic dest, next_dest;
    logic [aaie_addr_w-1:0] addr, next_addr;
    logic [aaie_data_w-1:0] operand, next_operand;
    logic [aaie_data_w-1:0] result, next_result;
    logic [aaie_data_w-1:0] next_working;
    logic c_res, next_c_res, dc_res, next_dc_res;
    logic next_carry, next_dc, next_zero;
    logic [aaie_data_w:0] sum;
    logic [aaie_nibble:0] low_sum;
    logic [aaie_op_hi-aaie_op_lo:0] opcode;

    assign opcode = insn[aaie_op_hi:aaie_op_lo];
    assign sum = {1'b0, working} + {1'b0, operand};
    assign low_sum = {1'b0, working[aaie_nibble-1:0]}
        + {1'b0, operand[aaie_nibble-1:0]};

    always_comb begin
        next_op = op;
        next_dest = dest;
        next_addr = addr;
        next_operand = operand;
        next_result = result;
        next_c_res = c_res;
        next_dc_res = dc_res;
        next_working = working;
        next_carry = carry_flag;
        next_dc = digit_carry_flag;
        next_zero = zero_flag;
        case (ph.phase)
            aaie_q1: begin
                next_op = aaie_alu_none;
                next_dest = aaie_dest_working;
                next_addr = insn[aaie_addr_w-1:0];
                next_operand = insn[aaie_data_w-1:0];
                if (opcode == aaie_op_and_literal_with_working) begin
                    next_op = aaie_alu_and_lit;
                end else if (opcode == aaie_op_add_working_and_file) begin
                    next_op = aaie_alu_add_file;
                    next_dest = insn[aaie_dest_bit];
                end else if (opcode == aaie_op_and_working_with_file) begin
                    next_op = aaie_alu_and_file;
                    next_dest = insn[aaie_dest_bit];
                end
            end
            aaie_q2: begin
                if (op == aaie_alu_add_file || op == aaie_alu_and_file) begin
                    next_operand = file_rdata;
                end
            end
            aaie_q3: begin
                if (op == aaie_alu_add_file) begin
                    next_result = sum[aaie_data_w-1:0];
                    next_c_res = sum[aaie_data_w];
                    next_dc_res = low_sum[aaie_nibble];
                end else begin
                    next_result = working & operand;
                end
            end
            aaie_q4: begin
                if (op != aaie_alu_none && dest == aaie_dest_working) begin
                    next_working = result;
                end
                if (op != aaie_alu_none) begin
                    next_zero = (result == '0);
                end
                if (op == aaie_alu_add_file) begin
                    next_carry = c_res;
                    next_dc = dc_res;
                end
            end
            default: begin
                next_op = aaie_alu_none;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            op <= aaie_alu_none;
            dest <= aaie_dest_working;
            addr <= '0;
            operand <= '0;
            result <= '0;
            c_res <= 1'b0;
            dc_res <= 1'b0;
            working <= aaie_w_reset;
            carry_flag <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else begin
            op <= next_op;
            dest <= next_dest;
            addr <= next_addr;
            operand <= next_operand;
            result <= next_result;
            c_res <= next_c_res;
            dc_res <= next_dc_res;
            working <= next_working;
            carry_flag <= next_carry;
            digit_carry_flag <= next_dc;
            zero_flag <= next_zero;
        end
    end

    assign file_addr = addr;
    assign file_wdata = result;
    assign file_rd = (ph.phase == aaie_q2)
        && (op == aaie_alu_add_file || op == aaie_alu_and_file);
    // destination 1 writes file in q4
    assign file_we = (ph.phase == aaie_q4) && (dest == aaie_dest_file)
        && (op == aaie_alu_add_file || op == aaie_alu_and_file);
    assign phase = ph.phase;
    assign insn_valid = (op != aaie_alu_none);

    // each decode sequence is anchored on the q1 sample of insn
    sequence s_lit_decoded;
        ph.cycle_start && opcode == aaie_op_and_literal_with_working;
    endsequence

    sequence s_add_decoded;
        ph.cycle_start && opcode == aaie_op_add_working_and_file;
    endsequence

    sequence s_unknown_decoded;
        ph.cycle_start && opcode != aaie_op_and_literal_with_working
        && opcode != aaie_op_add_working_and_file
        && opcode != aaie_op_and_working_with_file;
    endsequence

    // the add reaches its write phase three periods after decode
    sequence s_add_done;
        s_add_decoded ##3 ph.phase == aaie_q4;
    endsequence

    a_and_lit_w: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_lit_decoded |=> ##3 (working
        == ($past(working, 4) & $past(insn[aaie_data_w-1:0], 4))))
        else $error("literal and result wrong");
    a_and_lit_c: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_lit_decoded |=> ##3 $stable(carry_flag)
        && $stable(digit_carry_flag))
        else $error("literal and touched carry");
    a_and_lit_z: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_lit_decoded |=> ##3 zero_flag == (working == '0))
        else $error("literal and zero flag wrong");
    // operands seen at decode and at the read edge, not the alu registers
    a_add_carry: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_add_done |=> carry_flag == (({1'b0, $past(working, 4)}
        + {1'b0, $past(file_rdata, 3)}) >> aaie_data_w))
        else $error("add carry wrong");
    a_add_dcarry: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_add_done |=> digit_carry_flag
        == (({1'b0, $past(working[aaie_nibble-1:0], 4)}
        + {1'b0, $past(file_rdata[aaie_nibble-1:0], 3)}) >> aaie_nibble))
        else $error("add digit carry wrong");
    a_add_zero: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_add_done |=> zero_flag
        == (aaie_data_w'($past(working, 4) + $past(file_rdata, 3)) == '0))
        else $error("add zero flag wrong");
    a_dest_file: assert property (
        @(posedge clk_sys) disable iff (rst)
        file_we |-> dest == aaie_dest_file && ph.phase == aaie_q4)
        else $error("file write without file dest");
    a_dest_work: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ph.phase == aaie_q4 && dest == aaie_dest_file)
        |=> $stable(working))
        else $error("working changed on file dest");
    a_and_file_z: assert property (
        @(posedge clk_sys) disable iff (rst)
        (ph.phase == aaie_q4 && op == aaie_alu_and_file)
        |=> zero_flag == (file_wdata == '0) && $stable(carry_flag))
        else $error("file and flags wrong");
    a_read_q2: assert property (
        @(posedge clk_sys) disable iff (rst)
        file_rd |-> ph.phase == aaie_q2 ##2 ph.phase == aaie_q4)
        else $error("read outside q2");
    // unknown opcodes must leave the file port, working and zero flag alone
    a_unknown_nop: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_unknown_decoded |=> !file_rd ##2 !file_we
        ##1 $stable(working) && $stable(zero_flag))
        else $error("unknown opcode had an effect");
    a_addr_width: assert property (
        @(posedge clk_sys) disable iff (rst)
        ph.cycle_start |=> file_addr == $past(insn[aaie_addr_w-1:0]))
        else $error("address field wrong");
endmodule

/* File: aaie_exec_test.sv */
module aaie_exec_test;
    import aaie_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [13:0] insn;
        logic [7:0] rdata;
        logic [7:0] w;
        logic [7:0] wdata;
        logic c;
        logic dc;
        logic z;
        logic rd;
        logic we;
    } aaie_row_type;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [13:0] insn = 14'h0000;
    logic [7:0] file_rdata = 8'h00;
    logic [6:0] file_addr;
    logic file_rd, file_we, carry_flag, digit_carry_flag, zero_flag;
    logic [7:0] file_wdata, working;
    logic [1:0] phase;
    logic insn_valid;
    int err_total = 0;
    int n_compared = 0;
    // rows run in order, each one starts from the state the last one left
    aaie_row_type rows [10] = '{
        '{14'h077f, 8'h17, 8'h17, 8'h17, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{14'h0780, 8'hc2, 8'h17, 8'hd9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
        '{14'h0585, 8'hc2, 8'h17, 8'h02, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1},
        '{14'h072a, 8'hfc, 8'h13, 8'h13, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0},
        '{14'h395f, 8'h00, 8'h13, 8'h13, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
        '{14'h3900, 8'h00, 8'h00, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0},
        '{14'h0701, 8'h08, 8'h08, 8'h08, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0},
        '{14'h0701, 8'h08, 8'h10, 8'h10, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
        '{14'h3fff, 8'h00, 8'h10, 8'h10, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0},
        '{14'h0580, 8'hef, 8'h10, 8'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}
    };

    aaie_exec i_aaie_exec (
        .clk_sys(clk_sys),
        .rst(rst),
        .insn(insn),
        .file_rdata(file_rdata),
        .file_addr(file_addr),
        .file_rd(file_rd),
        .file_we(file_we),
        .file_wdata(file_wdata),
        .working(working),
        .carry_flag(carry_flag),
        .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag),
        .phase(phase),
        .insn_valid(insn_valid)
    );

    always #10 clk_sys = ~clk_sys;

    task automatic cmp_val(input string name, input logic [7:0] e,
                           input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic cmp_bit(input string name, input logic e, input logic g);
        cmp_val(name, {7'h00, e}, {7'h00, g});
    endtask

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one instruction, entered 2 ns after the edge that starts q1
    task automatic run(input aaie_row_type r);
        logic [5:0] op;
        op = r.insn[aaie_op_hi:aaie_op_lo];
        insn = r.insn;
        @(posedge clk_sys);
        #2;
        cmp_val("phase q2", 8'h01, {6'h00, phase});
        cmp_bit("file_rd", r.rd, file_rd);
        cmp_bit("insn_valid", op == aaie_op_and_literal_with_working
            || op == aaie_op_add_working_and_file
            || op == aaie_op_and_working_with_file, insn_valid);
        if (r.rd) begin
            cmp_val("addr", {1'b0, r.insn[6:0]}, {1'b0, file_addr});
        end
        file_rdata = r.rdata;
        @(posedge clk_sys);
        #2;
        // stale read data is inverted so a late sample shows up
        file_rdata = ~r.rdata;
        cmp_val("phase q3", 8'h03, {6'h00, phase});
        cmp_bit("file_rd q3", 1'b0, file_rd);
        @(posedge clk_sys);
        #2;
        cmp_val("phase q4", 8'h02, {6'h00, phase});
        cmp_bit("file_we", r.we, file_we);
        if (r.we) cmp_val("wdata", r.wdata, file_wdata);
        @(posedge clk_sys);
        #2;
        cmp_val("phase q1", 8'h00, {6'h00, phase});
        cmp_bit("file_we q1", 1'b0, file_we);
        cmp_val("working", r.w, working);
        cmp_bit("carry", r.c, carry_flag);
        cmp_bit("digit carry", r.dc, digit_carry_flag);
        cmp_bit("zero", r.z, zero_flag);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        // add, and-file, and-literal, unknown opcode, both destinations
        foreach (rows[i]) run(rows[i]);
        // reset in mid-instruction clears state and restarts at q1
        insn = 14'h0700;
        @(posedge clk_sys);
        #2;
        rst = 1'b1;
        #1;
        cmp_val("phase rst", 8'h00, {6'h00, phase});
        cmp_val("working rst", 8'h00, working);
        cmp_bit("zero rst", 1'b0, zero_flag);
        cmp_bit("dc rst", 1'b0, digit_carry_flag);
        cmp_bit("file_rd rst", 1'b0, file_rd);
        cmp_bit("valid rst", 1'b0, insn_valid);
        @(posedge clk_sys);
        #2;
        rst = 1'b0;
        run(aaie_row_type'{14'h0700, 8'h21, 8'h21, 8'h21, 1'b0, 1'b0,
            1'b0, 1'b1, 1'b0});
        // and with file, destination working: 0x21 and 0x0f gives 0x01
        run(aaie_row_type'{14'h0505, 8'h0f, 8'h01, 8'h01, 1'b0, 1'b0,
            1'b0, 1'b1, 1'b0});
        summarize();
    end

    // the whole run is about fifty cycles
    initial begin
        #5000;
        err_total++;
        summarize();
    end
endmodule
